// ===== core/ttm_bus_if.sv
// byte carrier between the serial front end and the timer core
`timescale 1ns/1ps
interface ttm_bus_if;
	logic byte_valid;
	logic byte_first;
	logic [7:0] byte_data;
	logic reply_load;
	logic [7:0] reply_byte;
	modport ser (output byte_valid, output byte_first, output byte_data, input reply_load, input reply_byte);
	modport core (input byte_valid, input byte_first, input byte_data, output reply_load, output reply_byte);
endinterface

// ===== core/ttm_pkg.sv
// constants, types and helpers for the tone timer and interrupt block
// Functional notes
// - no-tone timer loads with command 33 hex plus one data byte, any time
// - no-tone code n gives n x 20 ms, or n x 40 ms in mid band
// - no-tone register write accepted in every mode, receive or transmit
// - no-tone write only sets period; counting waits for a good measurement
// - no-tone timer is one-shot, reloaded by successful measurements and by signal fades while running
// - unusable signal starts countdown (code only reloads it on a fade while running); expiry sets no-tone flag and interrupt
// - with no signal, countdown starts when measurement complete flag sets
// - measurement over 75% done at expiry holds the flag until aborted
// - no-tone flag clears on status read, no-tone write or general reset
// - general reset sets both timer settings to code zero
// - interval timer loads with command 36 hex plus one data byte
// - interval code n gives n x 10 ms, or n x 20 ms in mid band
// - interval timer restarts as soon as its data byte is loaded
// - interval expiry sets status bit 2 and the enabled interrupt
// - interval timer reloads itself after expiry until rewritten or reset
// - interval flag held until status read, interval write or general reset
// - all-zero tone word powersaves that generator; both saved saves summer
// - clock and serial bus logic stay active under every powersave state
// - control bit 5 gates no-tone and measurement irq, bit 6 interval irq
// - status bit 0 measurement, bit 1 no-tone, bit 2 interval expired
// - read status command releases irq, shifts status out, clears flags
// - general reset is the single command byte 01 hex
// - serial bytes move msb first, sampled on rising serial clock
// - each byte acts only once fully received
package ttm_pkg;

	// ----------------------------------------
	// command bytes
	// ----------------------------------------
	localparam logic [7:0] CMD_GEN_RESET = 8'h01;
	localparam logic [7:0] CMD_CONTROL = 8'h30;
	localparam logic [7:0] CMD_READ_STATUS = 8'h31;
	localparam logic [7:0] CMD_NOTONE = 8'h33;
	localparam logic [7:0] CMD_TONE1 = 8'h34;
	localparam logic [7:0] CMD_TONE2 = 8'h35;
	localparam logic [7:0] CMD_INTERVAL = 8'h36;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int ST_MEAS = 0;
	localparam int ST_NOTONE = 1;
	localparam int ST_INTERVAL = 2;
	localparam int ST_W = 3;
	localparam int CTL_MID_BAND = 0;
	localparam int CTL_IE_RX = 5;
	localparam int CTL_IE_INTERVAL = 6;
	localparam int CODE_W = 4;
	localparam int CNT_W = 24;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;
	localparam logic [15:0] TONE_RESET = 16'h0000;
	localparam logic [ST_W-1:0] ST_RESET = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int UNIT_MS = 10;
	localparam int UNIT_CYC_DFLT = UNIT_MS * (CLK_HZ / 1000);
	localparam logic [2:0] NT_MULT_HIGH = 3'h2;
	localparam logic [2:0] NT_MULT_MID = 3'h4;
	localparam logic [2:0] IV_MULT_HIGH = 3'h1;
	localparam logic [2:0] IV_MULT_MID = 3'h2;

	typedef enum {NT_IDLE, NT_RUN, NT_HELD} ttm_nt_state_t;

	// period in clock cycles from a code, a band multiplier and the unit
	function automatic logic [CNT_W-1:0] ttm_period(input logic [CODE_W-1:0] code, input logic [2:0] mult,
		input logic [CNT_W-1:0] unit);
		logic [CNT_W-1:0] c;
		logic [CNT_W-1:0] m;
		c = {{(CNT_W-CODE_W){1'b0}}, code};
		m = {{(CNT_W-3){1'b0}}, mult};
		return c * m * unit;
	endfunction

endpackage

// ===== core/ttm_serial.sv
// serial control bus front end: byte receive and reply shift
`timescale 1ns/1ps
module ttm_serial
	import ttm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic csn_b,
	input wire logic serial_clk,
	input wire logic cmd_data,
	output logic reply_data,
	output logic reply_oe,
	ttm_bus_if.ser bus
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] cs_sync_reg;
	logic [1:0] ck_sync_reg;
	logic [1:0] dt_sync_reg;
	logic ck_last_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic first_reg;
	logic [7:0] reply_sh_reg;
	logic reply_act_reg;
	logic valid_reg;
	logic vfirst_reg;
	logic [7:0] vdata_reg;

	wire sel = ~cs_sync_reg[1];
	wire ck_rise = ck_sync_reg[1] & ~ck_last_reg;
	wire [7:0] shift_next = {shift_reg[6:0], dt_sync_reg[1]};
	wire byte_end = sel & ck_rise & (bit_cnt_reg == BIT_LAST);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_sync_reg <= 2'h3;
			ck_sync_reg <= 2'h0;
			dt_sync_reg <= 2'h0;
			ck_last_reg <= 1'b0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[0], csn_b};
			ck_sync_reg <= {ck_sync_reg[0], serial_clk};
			dt_sync_reg <= {dt_sync_reg[0], cmd_data};
			ck_last_reg <= ck_sync_reg[1];
		end
	end

	// ----------------------------------------
	// byte receive, msb first on rising clock
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			first_reg <= 1'b1;
		end else if (!sel) begin
			bit_cnt_reg <= 3'h0;
			first_reg <= 1'b1;
		end else if (ck_rise) begin
			shift_reg <= shift_next;
			bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
			if (bit_cnt_reg == BIT_LAST) begin
				first_reg <= 1'b0;
			end
		end
	end

	// whole byte only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			valid_reg <= 1'b0;
			vfirst_reg <= 1'b0;
			vdata_reg <= 8'h00;
		end else begin
			valid_reg <= byte_end;
			if (byte_end) begin
				vfirst_reg <= first_reg;
				vdata_reg <= shift_next;
			end
		end
	end

	// ----------------------------------------
	// reply shift, bit 7 driven first
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reply_sh_reg <= 8'h00;
			reply_act_reg <= 1'b0;
		end else if (!sel) begin
			reply_act_reg <= 1'b0;
		end else if (bus.reply_load) begin
			reply_sh_reg <= bus.reply_byte;
			reply_act_reg <= 1'b1;
		end else if (ck_rise && reply_act_reg) begin
			reply_sh_reg <= {reply_sh_reg[6:0], 1'b0};
		end
	end

	assign bus.byte_valid = valid_reg;
	assign bus.byte_first = vfirst_reg;
	assign bus.byte_data = vdata_reg;
	assign reply_data = reply_sh_reg[7];
	assign reply_oe = reply_act_reg;
endmodule

// ===== core/ttm_top.sv
// tone timers, status flags, interrupt and powersave control
`timescale 1ns/1ps
module ttm_top
	import ttm_pkg::*;
#(
	parameter int UNIT_CYC = ttm_pkg::UNIT_CYC_DFLT
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic csn_b,
	input wire logic serial_clk,
	input wire logic cmd_data,
	output logic reply_data,
	output logic reply_oe,
	output logic irq_b,
	input wire logic meas_done,
	input wire logic meas_abort,
	input wire logic meas_late,
	input wire logic signal_bad,
	output logic [7:0] control,
	output logic [15:0] tone1_word,
	output logic [15:0] tone2_word,
	output logic tone1_psave,
	output logic tone2_psave,
	output logic sum_psave
);
	import ttm_pkg::*;

	// ----------------------------------------
	// serial front end, never powersaved
	// ----------------------------------------
	ttm_bus_if bus ();

	ttm_serial u_serial (
		.clk(clk),
		.rst_b(rst_b),
		.csn_b(csn_b),
		.serial_clk(serial_clk),
		.cmd_data(cmd_data),
		.reply_data(reply_data),
		.reply_oe(reply_oe),
		.bus(bus)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] cmd_reg;
	logic data_idx_reg;
	logic [7:0] ctl_reg;
	logic [15:0] tone1_reg;
	logic [15:0] tone2_reg;
	logic [CODE_W-1:0] nt_code_reg;
	logic [CODE_W-1:0] iv_code_reg;
	logic [ST_W-1:0] st_reg;
	logic [ST_W-1:0] st_next;
	ttm_nt_state_t nt_state_reg;
	ttm_nt_state_t nt_state_next;
	logic [CNT_W-1:0] nt_cnt_reg;
	logic [CNT_W-1:0] nt_cnt_next;
	logic iv_run_reg;
	logic [CNT_W-1:0] iv_cnt_reg;
	logic sig_bad_last_reg;
	logic irq_b_reg;
	logic t1_ps_reg;
	logic t2_ps_reg;
	logic sum_ps_reg;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	wire first_byte = bus.byte_valid & bus.byte_first;
	wire data_byte = bus.byte_valid & ~bus.byte_first;
	wire gen_reset = first_byte & (bus.byte_data == CMD_GEN_RESET);
	wire status_rd = first_byte & (bus.byte_data == CMD_READ_STATUS);
	wire wr_ctl = data_byte & (cmd_reg == CMD_CONTROL) & ~data_idx_reg;
	wire wr_notone = data_byte & (cmd_reg == CMD_NOTONE) & ~data_idx_reg;
	wire wr_interval = data_byte & (cmd_reg == CMD_INTERVAL) & ~data_idx_reg;
	wire wr_t1_hi = data_byte & (cmd_reg == CMD_TONE1) & ~data_idx_reg;
	wire wr_t1_lo = data_byte & (cmd_reg == CMD_TONE1) & data_idx_reg;
	wire wr_t2_hi = data_byte & (cmd_reg == CMD_TONE2) & ~data_idx_reg;
	wire wr_t2_lo = data_byte & (cmd_reg == CMD_TONE2) & data_idx_reg;
	// upper nibble assumed zero by the controller
	wire [CODE_W-1:0] new_code = bus.byte_data[CODE_W-1:0];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_reg <= 8'h00;
			data_idx_reg <= 1'b0;
		end else if (first_byte) begin
			cmd_reg <= bus.byte_data;
			data_idx_reg <= 1'b0;
		end else if (data_byte) begin
			data_idx_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// control, tone and timer setting registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_reg <= CTL_RESET;
			tone1_reg <= TONE_RESET;
			tone2_reg <= TONE_RESET;
			nt_code_reg <= CODE_RESET;
			iv_code_reg <= CODE_RESET;
		end else if (gen_reset) begin
			ctl_reg <= CTL_RESET;
			tone1_reg <= TONE_RESET;
			tone2_reg <= TONE_RESET;
			nt_code_reg <= CODE_RESET;
			iv_code_reg <= CODE_RESET;
		end else begin
			if (wr_ctl) begin
				ctl_reg <= bus.byte_data;
			end
			if (wr_t1_hi) begin
				tone1_reg[15:8] <= bus.byte_data;
			end
			if (wr_t1_lo) begin
				tone1_reg[7:0] <= bus.byte_data;
			end
			if (wr_t2_hi) begin
				tone2_reg[15:8] <= bus.byte_data;
			end
			if (wr_t2_lo) begin
				tone2_reg[7:0] <= bus.byte_data;
			end
			if (wr_notone) begin
				nt_code_reg <= new_code;
			end
			if (wr_interval) begin
				iv_code_reg <= new_code;
			end
		end
	end

	// ----------------------------------------
	// period decode
	// ----------------------------------------
	wire mid_band = ctl_reg[CTL_MID_BAND];
	wire [CNT_W-1:0] unit_cyc = CNT_W'(UNIT_CYC);
	wire [2:0] nt_mult = mid_band ? NT_MULT_MID : NT_MULT_HIGH;
	wire [2:0] iv_mult = mid_band ? IV_MULT_MID : IV_MULT_HIGH;
	wire [CNT_W-1:0] nt_period = ttm_period(nt_code_reg, nt_mult, unit_cyc);
	wire [CNT_W-1:0] iv_period = ttm_period(iv_code_reg, iv_mult, unit_cyc);
	wire [CNT_W-1:0] iv_new_period = ttm_period(new_code, iv_mult, unit_cyc);

	// ----------------------------------------
	// no-tone one-shot
	// ----------------------------------------
	wire sig_fade = signal_bad & ~sig_bad_last_reg;
	wire nt_expire = (nt_state_reg == NT_RUN) & (nt_cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1});
	logic nt_set;

	always_comb begin
		nt_state_next = nt_state_reg;
		nt_cnt_next = nt_cnt_reg;
		nt_set = 1'b0;
		if (gen_reset || wr_notone) begin
			nt_state_next = NT_IDLE;
		end else if (meas_done) begin
			nt_state_next = NT_RUN;
			nt_cnt_next = nt_period;
		end else begin
			unique case (nt_state_reg)
				NT_IDLE: begin
					nt_state_next = NT_IDLE;
				end
				NT_RUN: begin
					if (sig_fade) begin
						nt_cnt_next = nt_period;
					end else if (nt_expire && meas_late) begin
						nt_state_next = NT_HELD;
					end else if (nt_expire) begin
						nt_state_next = NT_IDLE;
						nt_set = 1'b1;
					end else begin
						nt_cnt_next = CNT_W'(nt_cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1});
					end
				end
				NT_HELD: begin
					if (meas_abort) begin
						nt_state_next = NT_IDLE;
						nt_set = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nt_state_reg <= NT_IDLE;
			nt_cnt_reg <= {CNT_W{1'b0}};
			sig_bad_last_reg <= 1'b0;
		end else begin
			nt_state_reg <= nt_state_next;
			nt_cnt_reg <= nt_cnt_next;
			sig_bad_last_reg <= signal_bad;
		end
	end

	// ----------------------------------------
	// interval timer, self repeating
	// ----------------------------------------
	wire iv_expire = iv_run_reg & (iv_cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			iv_run_reg <= 1'b0;
			iv_cnt_reg <= {CNT_W{1'b0}};
		end else if (gen_reset) begin
			iv_run_reg <= 1'b0;
		end else if (wr_interval) begin
			iv_run_reg <= 1'b1;
			iv_cnt_reg <= iv_new_period;
		end else if (iv_expire) begin
			iv_cnt_reg <= iv_period;
		end else if (iv_run_reg) begin
			iv_cnt_reg <= CNT_W'(iv_cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	// ----------------------------------------
	// status flags, set wins over clear
	// ----------------------------------------
	wire [ST_W-1:0] st_set = {iv_expire, nt_set, meas_done};
	wire [ST_W-1:0] st_clr = {status_rd | gen_reset | wr_interval,
		status_rd | gen_reset | wr_notone,
		status_rd | gen_reset};

	assign st_next = (st_reg & ~st_clr) | st_set;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// status byte loaded into the reply shifter
	assign bus.reply_load = status_rd;
	assign bus.reply_byte = {{(8-ST_W){1'b0}}, st_reg};

	// ----------------------------------------
	// interrupt and powersave outputs
	// ----------------------------------------
	wire rx_irq = (st_reg[ST_MEAS] | st_reg[ST_NOTONE]) & ctl_reg[CTL_IE_RX];
	wire iv_irq = st_reg[ST_INTERVAL] & ctl_reg[CTL_IE_INTERVAL];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_b_reg <= 1'b1;
			t1_ps_reg <= 1'b1;
			t2_ps_reg <= 1'b1;
			sum_ps_reg <= 1'b1;
		end else begin
			irq_b_reg <= ~(rx_irq | iv_irq);
			t1_ps_reg <= (tone1_reg == TONE_RESET);
			t2_ps_reg <= (tone2_reg == TONE_RESET);
			sum_ps_reg <= (tone1_reg == TONE_RESET) & (tone2_reg == TONE_RESET);
		end
	end

	assign irq_b = irq_b_reg;
	assign control = ctl_reg;
	assign tone1_word = tone1_reg;
	assign tone2_word = tone2_reg;
	assign tone1_psave = t1_ps_reg;
	assign tone2_psave = t2_ps_reg;
	assign sum_psave = sum_ps_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_flags_gone;
		st_reg == ST_RESET;
	endsequence

	sequence s_irq_off;
		irq_b;
	endsequence

	chk_status_read_release: assert property (
		status_rd && (st_set == ST_RESET) |=> s_flags_gone ##1 s_irq_off)
		else $error("status read did not clear flags and release irq");

	chk_notone_primed_only: assert property (
		wr_notone && !gen_reset |=> (nt_state_reg == NT_IDLE) && !st_reg[ST_NOTONE])
		else $error("no-tone write started the timer or left the flag");

	chk_interval_load: assert property (
		wr_interval && !gen_reset |=> iv_run_reg && (iv_cnt_reg == $past(iv_new_period)))
		else $error("interval timer not restarted by its write");

	chk_interval_repeat: assert property (
		iv_expire && !wr_interval && !gen_reset
		|=> iv_run_reg && st_reg[ST_INTERVAL] && (iv_cnt_reg == $past(iv_period)))
		else $error("interval timer did not reload and flag after expiry");

	chk_notone_late_hold: assert property (
		nt_expire && meas_late && !meas_done && !sig_fade && !gen_reset && !wr_notone
		|=> (nt_state_reg == NT_HELD) && (st_reg[ST_NOTONE] == $past(st_reg[ST_NOTONE] && !status_rd)))
		else $error("late measurement did not hold the no-tone flag");

	chk_notone_expire_flag: assert property (
		nt_expire && !meas_late && !meas_done && !sig_fade && !gen_reset && !wr_notone
		|=> st_reg[ST_NOTONE] ##1 (irq_b == !($past(ctl_reg[CTL_IE_RX]) || $past(iv_irq))))
		else $error("no-tone expiry did not set flag");

	chk_gen_reset_codes: assert property (
		gen_reset |=> (nt_code_reg == CODE_RESET) && (iv_code_reg == CODE_RESET) && (ctl_reg == CTL_RESET) && !iv_run_reg)
		else $error("general reset left timer settings");

	chk_sum_powersave: assert property (
		((tone1_reg == TONE_RESET) && (tone2_reg == TONE_RESET)) [*2] |-> sum_psave && tone1_psave && tone2_psave)
		else $error("summer not powersaved with both generators off");

	chk_meas_set_wins: assert property (
		meas_done |=> st_reg[ST_MEAS])
		else $error("measurement flag lost");

	chk_irq_gate_off: assert property (
		(!ctl_reg[CTL_IE_RX] && !ctl_reg[CTL_IE_INTERVAL]) [*2] |-> irq_b)
		else $error("irq asserted with interrupts disabled");

	chk_notone_rerun: assert property (
		meas_done && !gen_reset && !wr_notone |=> (nt_state_reg == NT_RUN) && (nt_cnt_reg == $past(nt_period)))
		else $error("measurement did not restart the no-tone timer");

	chk_fade_restart: assert property (
		(nt_state_reg == NT_RUN) && sig_fade && !meas_done && !gen_reset && !wr_notone
		|=> (nt_state_reg == NT_RUN) && (nt_cnt_reg == $past(nt_period)))
		else $error("signal fade did not restart the no-tone countdown");

	chk_interval_clear: assert property (
		wr_interval && !iv_expire |=> !st_reg[ST_INTERVAL])
		else $error("interval write did not clear its flag");
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the tone timer block
`timescale 1ns/1ps
module tb_top;
	import ttm_pkg::*;
	logic clk, rst_b, csn_b, serial_clk, cmd_data, reply_data, reply_oe, irq_b;
	logic meas_done, meas_abort, meas_late, signal_bad;
	logic tone1_psave, tone2_psave, sum_psave;
	logic [7:0] control;
	logic [15:0] tone1_word, tone2_word;
	logic [7:0] expq[$];
	int fail_count = 0;
	int num_checks = 0;
	time fall_t = 0;

	ttm_top #(.UNIT_CYC(20)) i_ttm_top (.clk(clk), .rst_b(rst_b), .csn_b(csn_b), .serial_clk(serial_clk),
		.cmd_data(cmd_data), .reply_data(reply_data), .reply_oe(reply_oe), .irq_b(irq_b),
		.meas_done(meas_done), .meas_abort(meas_abort), .meas_late(meas_late), .signal_bad(signal_bad),
		.control(control), .tone1_word(tone1_word), .tone2_word(tone2_word), .tone1_psave(tone1_psave),
		.tone2_psave(tone2_psave), .sum_psave(sum_psave));
	ttm_ctrl_model i_ttm_ctrl_model (.clk(clk), .csn_b(csn_b), .serial_clk(serial_clk), .cmd_data(cmd_data),
		.reply_data(reply_data), .reply_oe(reply_oe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(negedge irq_b) fall_t = $time;

	// ----
	// helpers
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
		i_ttm_ctrl_model.frame(cmd, n, d, 1'b0);
	endtask
	task automatic see(input logic [7:0] e);
		expq.push_back(e);
		i_ttm_ctrl_model.frame(CMD_READ_STATUS, 0, 16'h0000, 1'b1);
	endtask
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (irq_b !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic pulse(input logic abort, output time t);
		@(posedge clk);
		if (abort) meas_abort <= 1'b1;
		else meas_done <= 1'b1;
		@(posedge clk);
		meas_abort <= 1'b0;
		meas_done <= 1'b0;
		t = $time;
	endtask

	initial forever begin
		@(i_ttm_ctrl_model.got);
		chk(i_ttm_ctrl_model.got_byte, expq.size() ? expq.pop_front() : 16'hffff);
	end
	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		give_verdict();
	end

	// ----
	// main sequence
	// ----
	initial begin
		int c, p, d, m;
		logic [15:0] w, w1, w2;
		time t0, t1;
		rst_b = 1'b0;
		meas_done = 1'b0;
		meas_abort = 1'b0;
		meas_late = 1'b0;
		signal_bad = 1'b0;
		w1 = 16'h0000;
		w2 = 16'h0000;
		void'($urandom(81836));
		repeat (16) @(posedge clk);
		chk({reply_oe, irq_b, tone1_psave, tone2_psave, sum_psave, control}, 16'h0f00);
		rst_b <= 1'b1;
		wr(CMD_GEN_RESET, 0, 16'h0000);
		see(8'h00);
		for (int b = 0; b < 2; b++) begin
			c = $urandom_range(15, 1);
			p = c * (b + 1) * 20;
			wr(CMD_CONTROL, 1, b ? 16'h41 : 16'h40);
			chk(control, b ? 16'h41 : 16'h40);
			wr(CMD_INTERVAL, 1, 16'(c));
			wait_irq(700);
			d = int'((fall_t - i_ttm_ctrl_model.rise_t) / 50);
			chk(d >= p + 2 && d <= p + 12, 1'b1);
			t1 = fall_t;
			see(8'h04);
			wait_irq(700);
			d = int'((fall_t - t1) / 50);
			chk(d > 0 && d % p == 0, 1'b1);
			wr(CMD_GEN_RESET, 0, 16'h0000);
			repeat (2 * p) @(negedge clk);
			see(8'h00);
		end
		wr(CMD_CONTROL, 1, 16'h00);
		wr(CMD_INTERVAL, 1, 16'h02);
		repeat (200) @(negedge clk);
		chk(irq_b, 1'b1);
		see(8'h04);
		wr(CMD_INTERVAL, 1, 16'h0f);
		see(8'h00);
		wr(CMD_GEN_RESET, 0, 16'h0000);
		m = $urandom_range(1, 0);
		wr(CMD_CONTROL, 1, 16'(32 + m));
		c = $urandom_range(15, 12 - 4 * m);
		p = c * 40 * (m + 1);
		wr(CMD_NOTONE, 1, 16'(c));
		repeat (2 * p) @(negedge clk);
		chk(irq_b, 1'b1);
		for (int s = 0; s < 4; s++) begin
			pulse(1'b0, t0);
			wait_irq(5);
			chk(irq_b, 1'b0);
			see(8'h01);
			if (s == 1) begin
				while ($time < t0 + p * 25) @(negedge clk);
				@(posedge clk) signal_bad <= 1'b1;
				@(posedge clk) t0 = $time;
			end
			if (s == 2) meas_late <= 1'b1;
			if (s == 3) wr(CMD_NOTONE, 1, 16'(c));
			wait_irq(p + 20);
			if (s < 2) begin
				d = int'((fall_t - t0) / 50);
				chk(d >= p && d <= p + 4, 1'b1);
				if (s == 1) wr(CMD_NOTONE, 1, 16'(c));
				see(s ? 8'h00 : 8'h02);
				signal_bad <= 1'b0;
				repeat (2 * p) @(negedge clk);
				chk(irq_b, 1'b1);
			end else begin
				chk(irq_b, 1'b1);
				if (s == 2) begin
					pulse(1'b1, t1);
					meas_late <= 1'b0;
					wait_irq(5);
					chk(irq_b, 1'b0);
					see(8'h02);
				end
			end
		end
		for (int s = 0; s < 4; s++) begin
			w = s < 2 ? 16'($urandom_range(65535, 1)) : 16'h0000;
			if (s % 2) w2 = w;
			else w1 = w;
			wr(s % 2 ? CMD_TONE2 : CMD_TONE1, 2, w);
			chk(s % 2 ? tone2_word : tone1_word, w);
			chk({tone1_psave, tone2_psave, sum_psave}, {w1 == 0, w2 == 0, w1 == 0 && w2 == 0});
		end
		wr(8'h77, 1, 16'h00ff);
		chk(control, 16'(32 + m));
		see(8'h00);
		wr(CMD_GEN_RESET, 0, 16'h0000);
		chk(control, 8'h00);
		give_verdict();
	end
endmodule

// ===== sim/ttm_ctrl_model.sv
// controller model on the serial control bus
`timescale 1ns/1ps
module ttm_ctrl_model
	import ttm_pkg::*;
(
	input wire logic clk,
	output logic csn_b,
	output logic serial_clk,
	output logic cmd_data,
	input wire logic reply_data,
	input wire logic reply_oe
);
	import ttm_pkg::*;
	logic last_bit;
	logic reply_line;
	logic [7:0] got_byte;
	time rise_t;
	event got;

	// released reply line shows the inverse of its last driven bit
	assign reply_line = reply_oe ? reply_data : ~last_bit;

	initial begin
		csn_b = 1'b1;
		serial_clk = 1'b0;
		cmd_data = 1'b0;
		last_bit = 1'b0;
		rise_t = 0;
	end

	// ----
	// byte and frame transfers, clock idle low outside frames
	// ----
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			cmd_data <= tx[i];
			repeat (4) @(posedge clk);
			serial_clk <= 1'b1;
			rx[i] = reply_line;
			rise_t = $time;
			if (reply_oe) last_bit = reply_data;
			repeat (4) @(posedge clk);
			serial_clk <= 1'b0;
		end
	endtask

	task automatic frame(input logic [7:0] cmd, input int n, input logic [15:0] dat, input logic rd);
		logic [7:0] rx;
		@(posedge clk);
		csn_b <= 1'b0;
		repeat (40) @(posedge clk);
		xfer(cmd, rx);
		for (int k = n - 1; k >= 0; k--)
			xfer(dat[8*k +: 8], rx);
		if (rd) begin
			xfer(8'h00, rx);
			got_byte = rx;
			->got;
		end
		repeat (8) @(posedge clk);
		csn_b <= 1'b1;
		repeat (40) @(posedge clk);
	endtask
endmodule
